// *** hdl/ext_mem_pin_map.vh ***
// constants for the external memory interface pin sharing logic
`ifndef EXT_MEM_PIN_MAP_VH
`define EXT_MEM_PIN_MAP_VH
// =====================================================================
// mode encoding
`define MODE_SRAM 1'b0
`define MODE_DRAM 1'b1
// =====================================================================
// static-ram address bit positions on the shared pins
`define SRAM_BIT_PIN_A 9
`define SRAM_BIT_PIN_B 8
`define SRAM_BIT_PIN_C 12
`define SRAM_BIT_ROW 13
`define SRAM_BIT_PIN_D 10
`define SRAM_BIT_PIN_E 11
// dynamic-ram address bit positions on the shared pins
`define DRAM_BIT_PIN_A 5
`define DRAM_BIT_PIN_B 4
`define DRAM_BIT_PIN_C 8
`define DRAM_BIT_PIN_D 6
`define DRAM_BIT_PIN_E 7
// dynamic-ram address bits on the high nibble start here
`define DRAM_HI_NIBBLE_LSB 0
// =====================================================================
// reset values
`define RST_STROBE 1'b1
`define RST_NIBBLE 4'hf
`define RST_OE 4'h0
`define RST_HI_OE 4'hf
`define RST_PIN_OE 1'b0
`define RST_CAPTURE 1'b0
`define RST_RDATA 8'h00
// read data upper half in dram mode, where only the low nibble carries data
`define DRAM_RDATA_PAD 4'h0
`endif

// *** hdl/ext_memory_pin_mode_mux.v ***
// pin sharing for the dsp external memory interface, sram or dram mode
//
// Summary of operation
// - pin a: sram address 9, dram 5
// - pin b: sram address 8, dram 4
// - pin c: sram address 12, dram 8
// - row pin: sram address 13, dram ras
// - one write strobe in both modes
// - shared pin: sram ale, dram cas
// - low nibble: sram addr/data, dram data
// - high nibble: sram addr/data, dram address
// - one read strobe in both modes
// - pin d: sram address 10, dram 6
// - pin e: sram address 11, dram 7
`timescale 1ns/10ps
`include "ext_mem_pin_map.vh"
module ext_memory_pin_mode_mux #(
  parameter ADDR_W = 14
) (
  input wire clk_sys_in,
  input wire rstn_in,
  input wire dram_mode_in,
  input wire [ADDR_W-1:0] sram_addr_in,
  input wire [ADDR_W-1:0] dram_addr_in,
  input wire [7:0] wdata_in,
  input wire ad_drive_in,
  input wire wdata_drive_in,
  input wire ale_in,
  input wire ras_n_in,
  input wire cas_n_in,
  input wire write_n_in,
  input wire read_n_in,
  input wire [3:0] shared_ad_low_nibble_in,
  input wire [3:0] shared_ad_high_nibble_in,
  output reg mem_addr_pin_a_out,
  output reg mem_addr_pin_b_out,
  output reg mem_addr_pin_c_out,
  output reg mem_addr_pin_d_out,
  output reg mem_addr_pin_e_out,
  output reg mem_addr_or_row_strobe_out,
  output reg mem_write_strobe_n_out,
  output reg mem_read_strobe_n_out,
  output reg mem_ale_or_col_strobe_out,
  output wire [3:0] shared_ad_low_nibble_out,
  output wire [3:0] shared_ad_low_nibble_oe_out,
  output reg [3:0] shared_ad_high_nibble_out,
  output reg [3:0] shared_ad_high_nibble_oe_out,
  output reg [7:0] rdata_out
);
  reg mode;
  // next values of the pin registers, chosen by the mode
  reg next_pin_a;
  reg next_pin_b;
  reg next_pin_c;
  reg next_pin_d;
  reg next_pin_e;
  reg next_row;
  reg next_col;
  reg [7:0] next_rdata;
  reg [3:0] next_low;
  reg next_low_oe;
  reg [3:0] next_high;
  reg next_high_oe;
  wire [3:0] low_rdata;

  // =====================================================================
  // single mode select for all shared pins
  // one flop feeds every pin mux, so no pin can switch a cycle ahead of the others;
  // the mode thus takes effect one edge later than the data it steers
  always @(posedge clk_sys_in)
  begin
    if (!rstn_in)
      mode <= `MODE_SRAM;
    else
      mode <= dram_mode_in;
  end

  // =====================================================================
  // low nibble source: dram data, or the sram address ahead of its data
  always @*
  begin
    if (mode == `MODE_DRAM)
    begin
      next_low = wdata_in[3:0];
      next_low_oe = wdata_drive_in;
    end
    else
    begin
      next_low = ad_drive_in ? sram_addr_in[3:0] : wdata_in[3:0];
      next_low_oe = ad_drive_in | wdata_drive_in;
    end
  end

  // =====================================================================
  // high nibble source: dram carries low address bits and is always driven
  always @*
  begin
    if (mode == `MODE_DRAM)
    begin
      next_high = dram_addr_in[`DRAM_HI_NIBBLE_LSB+3:`DRAM_HI_NIBBLE_LSB];
      next_high_oe = 1'b1;
    end
    else
    begin
      next_high = ad_drive_in ? sram_addr_in[7:4] : wdata_in[7:4];
      next_high_oe = ad_drive_in | wdata_drive_in;
    end
  end

  // =====================================================================
  // address, shared strobe and read capture sources from the current mode
  always @*
  begin
    if (mode == `MODE_DRAM)
    begin
      next_pin_a = dram_addr_in[`DRAM_BIT_PIN_A];
      next_pin_b = dram_addr_in[`DRAM_BIT_PIN_B];
      next_pin_c = dram_addr_in[`DRAM_BIT_PIN_C];
      next_pin_d = dram_addr_in[`DRAM_BIT_PIN_D];
      next_pin_e = dram_addr_in[`DRAM_BIT_PIN_E];
      next_row = ras_n_in;
      next_col = cas_n_in;
      next_rdata = {`DRAM_RDATA_PAD, low_rdata}; // high pins carry address here
    end
    else
    begin
      next_pin_a = sram_addr_in[`SRAM_BIT_PIN_A];
      next_pin_b = sram_addr_in[`SRAM_BIT_PIN_B];
      next_pin_c = sram_addr_in[`SRAM_BIT_PIN_C];
      next_pin_d = sram_addr_in[`SRAM_BIT_PIN_D];
      next_pin_e = sram_addr_in[`SRAM_BIT_PIN_E];
      next_row = sram_addr_in[`SRAM_BIT_ROW];
      next_col = ale_in;
      next_rdata = {shared_ad_high_nibble_in, low_rdata};
    end
  end

  // =====================================================================
  // registered address pins, parked high in reset
  always @(posedge clk_sys_in)
  begin
    if (!rstn_in)
    begin
      mem_addr_pin_a_out <= `RST_STROBE;
      mem_addr_pin_b_out <= `RST_STROBE;
      mem_addr_pin_c_out <= `RST_STROBE;
      mem_addr_pin_d_out <= `RST_STROBE;
      mem_addr_pin_e_out <= `RST_STROBE;
    end
    else
    begin
      mem_addr_pin_a_out <= next_pin_a;
      mem_addr_pin_b_out <= next_pin_b;
      mem_addr_pin_c_out <= next_pin_c;
      mem_addr_pin_d_out <= next_pin_d;
      mem_addr_pin_e_out <= next_pin_e;
    end
  end

  // =====================================================================
  // registered strobes, idle high so the ram stays deselected in reset
  always @(posedge clk_sys_in)
  begin
    if (!rstn_in)
    begin
      mem_addr_or_row_strobe_out <= `RST_STROBE;
      mem_ale_or_col_strobe_out <= `RST_STROBE;
      mem_write_strobe_n_out <= `RST_STROBE;
      mem_read_strobe_n_out <= `RST_STROBE;
    end
    else
    begin
      mem_addr_or_row_strobe_out <= next_row;
      mem_ale_or_col_strobe_out <= next_col;
      mem_write_strobe_n_out <= write_n_in;
      mem_read_strobe_n_out <= read_n_in;
    end
  end

  // =====================================================================
  // registered high nibble, driven high in reset
  always @(posedge clk_sys_in)
  begin
    if (!rstn_in)
    begin
      shared_ad_high_nibble_out <= `RST_NIBBLE;
      shared_ad_high_nibble_oe_out <= `RST_HI_OE;
    end
    else
    begin
      shared_ad_high_nibble_out <= next_high;
      shared_ad_high_nibble_oe_out <= {4{next_high_oe}};
    end
  end

  // =====================================================================
  // read capture; the low half has already passed the cell flop
  always @(posedge clk_sys_in)
  begin
    if (!rstn_in)
      rdata_out <= `RST_RDATA;
    else
      rdata_out <= next_rdata;
  end

  // =====================================================================
  // low nibble cell, released to input during reset
  nibble_pin_cell #(
    .WIDTH(4)
  ) low_cell (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .data_in(next_low),
    .oe_in(next_low_oe),
    .pin_in(shared_ad_low_nibble_in),
    .pin_out(shared_ad_low_nibble_out),
    .pin_oe_out(shared_ad_low_nibble_oe_out),
    .rdata_out(low_rdata)
  );
endmodule

// *** hdl/nibble_pin_cell.v ***
// one registered bidirectional nibble of shared pins
`timescale 1ns/10ps
`include "ext_mem_pin_map.vh"
module nibble_pin_cell #(
  parameter WIDTH = 4
) (
  input wire clk_sys_in,
  input wire rstn_in,
  input wire [WIDTH-1:0] data_in,
  input wire oe_in,
  input wire [WIDTH-1:0] pin_in,
  output reg [WIDTH-1:0] pin_out,
  output reg [WIDTH-1:0] pin_oe_out,
  output reg [WIDTH-1:0] rdata_out
);
  genvar i;
  // =====================================================================
  // per-bit output, enable and capture flops
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : bit_cell
      always @(posedge clk_sys_in)
      begin
        if (!rstn_in)
        begin
          pin_out[i] <= `RST_STROBE;
          pin_oe_out[i] <= `RST_PIN_OE;
          rdata_out[i] <= `RST_CAPTURE;
        end
        else
        begin
          pin_out[i] <= data_in[i];
          pin_oe_out[i] <= oe_in;
          rdata_out[i] <= pin_in[i];
        end
      end
    end
  endgenerate
endmodule

// *** test/ext_memory_pin_mode_mux_checker.sv ***
// assertions on the shared memory pins
`timescale 1ns/10ps
module ext_memory_pin_mode_mux_checker #(parameter ADDR_W = 14) (
  input wire clk_sys_in, rstn_in, dram_mode_in, ras_n_in, cas_n_in, ale_in, write_n_in,
  input wire wdata_drive_in,
  input wire [ADDR_W-1:0] sram_addr_in, dram_addr_in,
  input wire mem_addr_pin_a_out, mem_addr_pin_c_out, mem_addr_pin_d_out,
  input wire mem_addr_or_row_strobe_out, mem_ale_or_col_strobe_out, mem_write_strobe_n_out,
  input wire [3:0] shared_ad_low_nibble_oe_out, shared_ad_high_nibble_oe_out
);
  // =========
  // mirror of the mode flop, cleared to sram in reset
  reg md = 1'b0;
  always @(posedge clk_sys_in)
    md <= rstn_in & dram_mode_in;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  sequence up;
    rstn_in ##1 rstn_in;
  endsequence
  a_pin_a_map:
  assert property (up |-> mem_addr_pin_a_out ==
    ($past(md) ? $past(dram_addr_in[5]) : $past(sram_addr_in[9]))) else $error("pin a");
  a_pin_c_map:
  assert property (up |-> mem_addr_pin_c_out ==
    ($past(md) ? $past(dram_addr_in[8]) : $past(sram_addr_in[12]))) else $error("pin c");
  a_pin_d_map:
  assert property (up |-> mem_addr_pin_d_out ==
    ($past(md) ? $past(dram_addr_in[6]) : $past(sram_addr_in[10]))) else $error("pin d");
  a_row_strobe_map:
  assert property (up |-> mem_addr_or_row_strobe_out ==
    ($past(md) ? $past(ras_n_in) : $past(sram_addr_in[13]))) else $error("row pin");
  a_ale_cas_map:
  assert property (up |-> mem_ale_or_col_strobe_out ==
    ($past(md) ? $past(cas_n_in) : $past(ale_in))) else $error("ale pin");
  a_write_strobe_copy:
  assert property (up |-> mem_write_strobe_n_out == $past(write_n_in)) else $error("write");
  a_dram_hi_driven:
  assert property (up ##0 $past(md) |-> shared_ad_high_nibble_oe_out == 4'hf) else $error("hi oe");
  a_dram_lo_drive:
  assert property (up ##0 $past(md) |->
    shared_ad_low_nibble_oe_out == {4{$past(wdata_drive_in)}}) else $error("lo oe");
  a_reset_idle_levels:
  assert property (disable iff (1'b0) !rstn_in |=> mem_write_strobe_n_out && mem_addr_pin_a_out
    && shared_ad_low_nibble_oe_out == 4'h0) else $error("reset levels");
endmodule

// *** test/ext_memory_pin_mode_mux_tb.sv ***
// self-checking bench for the pin sharing mux
`timescale 1ns/10ps
`define CHK(g, x) begin n_tests++; if ((g) !== (x)) begin errors++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, x); end end
module ext_memory_pin_mode_mux_tb;
  logic clk_sys_in = 0, rstn_in = 0, dm = 0, ad = 0, wd = 0;
  logic [13:0] sa = 0, da = 0;
  logic [7:0] wdat = 0;
  logic [4:0] st = 5'h1f; // ale ras cas write read
  wire [3:0] lo_o, lo_oe, lo_i, hi_o, hi_oe, hi_i;
  wire [7:0] rd_data;
  // released high pins show the inverse of the level the design offers
  assign hi_i = hi_oe & hi_o | ~hi_oe & ~hi_o;
  wire a, b, c, d, e, row, wr, rd, ac;
  int errors = 0, n_tests = 0, cyc = 0, seed = 9310;
  // =========
  // design and far side
  ext_memory_pin_mode_mux dut_u (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .dram_mode_in(dm), .sram_addr_in(sa), .dram_addr_in(da), .wdata_in(wdat),
    .ad_drive_in(ad), .wdata_drive_in(wd), .ale_in(st[4]), .ras_n_in(st[3]),
    .cas_n_in(st[2]), .write_n_in(st[1]), .read_n_in(st[0]),
    .shared_ad_low_nibble_in(lo_i), .shared_ad_high_nibble_in(hi_i),
    .mem_addr_pin_a_out(a), .mem_addr_pin_b_out(b), .mem_addr_pin_c_out(c),
    .mem_addr_pin_d_out(d), .mem_addr_pin_e_out(e), .mem_addr_or_row_strobe_out(row),
    .mem_write_strobe_n_out(wr), .mem_read_strobe_n_out(rd), .mem_ale_or_col_strobe_out(ac),
    .shared_ad_low_nibble_out(lo_o), .shared_ad_low_nibble_oe_out(lo_oe),
    .shared_ad_high_nibble_out(hi_o), .shared_ad_high_nibble_oe_out(hi_oe), .rdata_out(rd_data));
  ext_ram_model ram_u (.clk_sys_in(clk_sys_in), .rd_n_in(rd), .wr_n_in(wr), .dev_in(lo_o),
    .dev_oe_in(lo_oe), .pin_out(lo_i));
  initial
    forever #4 clk_sys_in = ~clk_sys_in;
  // cycle ceiling against hangs
  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // expected pin a..e levels: dram or sram address bits
  function automatic logic [4:0] exp_addr(input logic m, input logic [13:0] s,
    input logic [13:0] r);
    exp_addr = m ? {r[5], r[4], r[8], r[6], r[7]} : {s[9], s[8], s[12], s[10], s[11]};
  endfunction
  // expected low nibble {pins, enables}: dram data, sram address before data
  function automatic logic [7:0] exp_lo(input logic m, input logic a, input logic w,
    input logic [13:0] s, input logic [7:0] x);
    exp_lo = m ? {x[3:0], {4{w}}} : {a ? s[3:0] : x[3:0], {4{a | w}}};
  endfunction
  // expected high nibble {pins, enables}: dram low address, always driven
  function automatic logic [7:0] exp_hi(input logic m, input logic a, input logic w,
    input logic [13:0] s, input logic [13:0] r, input logic [7:0] x);
    exp_hi = m ? {r[3:0], 4'hf} : {a ? s[7:4] : x[7:4], {4{a | w}}};
  endfunction
  // reset for n cycles, check idle levels, release
  task automatic rst_chk(input int n);
    @(posedge clk_sys_in);
    rstn_in <= 0;
    repeat (n) @(posedge clk_sys_in);
    #1;
    `CHK({a, b, c, d, e, row, wr, rd, ac, lo_oe, hi_oe}, {9'h1ff, 4'h0, 4'hf})
    `CHK({lo_o, rd_data}, {4'hf, 8'h00})
    @(posedge clk_sys_in);
    rstn_in <= 1;
    // first edge after release still uses the sram map that reset chose
    @(posedge clk_sys_in);
    #1;
    `CHK({a, b, c, d, e, row}, {exp_addr(1'b0, sa, da), sa[13]})
    $display("reset test done");
  endtask
  // random traffic in one mode, first beat a corner pattern
  task automatic run(input logic m, input int n);
    @(posedge clk_sys_in);
    dm <= m;
    repeat (2) @(posedge clk_sys_in);
    for (int k = 0; k < n; k++)
    begin
      @(posedge clk_sys_in);
      sa <= (k == 0) ? 14'h3fff : 14'($random(seed));
      da <= (k == 0) ? 14'h0 : 14'($random(seed));
      wdat <= 8'($random(seed));
      st <= 5'($random(seed));
      ad <= 1'($random(seed));
      wd <= 1'($random(seed));
      @(posedge clk_sys_in);
      #1;
      `CHK({a, b, c, d, e}, exp_addr(m, sa, da))
      `CHK(row, m ? st[3] : sa[13])
      `CHK({wr, rd}, st[1:0])
      `CHK(ac, m ? st[2] : st[4])
      `CHK({lo_o, lo_oe}, exp_lo(m, ad, wd, sa, wdat))
      `CHK({hi_o, hi_oe}, exp_hi(m, ad, wd, sa, da, wdat))
      // hold the beat two more edges: low pins reach the read port through two flops
      repeat (2) @(posedge clk_sys_in);
      #1;
      `CHK(rd_data, m ? {4'h0, lo_i} : {hi_i, lo_i})
    end
    $display("mode %0d test done", m);
  endtask
  initial
  begin
    rst_chk(20);
    run(1, 60);
    run(0, 60);
    run(1, 40);
    rst_chk(2);
    run(0, 40);
    give_verdict();
  end
endmodule
bind ext_memory_pin_mode_mux ext_memory_pin_mode_mux_checker #(.ADDR_W(ADDR_W)) chk_u (.*);

// *** test/ext_ram_model.sv ***
// behavioural external ram on the low data nibble
`timescale 1ns/10ps
module ext_ram_model (
  input wire clk_sys_in,
  input wire rd_n_in,
  input wire wr_n_in,
  input wire [3:0] dev_in,
  input wire [3:0] dev_oe_in,
  output logic [3:0] pin_out
);
  logic [3:0] mem = 4'h0;
  logic [3:0] last = 4'h0;
  // wire level: device drive wins, ram answers reads, else floats to inverse
  always_comb
    for (int i = 0; i < 4; i++)
      pin_out[i] = dev_oe_in[i] ? dev_in[i] : (!rd_n_in ? mem[i] : ~last[i]);
  // keep the last level and take writes
  always @(posedge clk_sys_in)
  begin
    // only a driven level is remembered, so a released pin holds its inverse steady
    last <= (dev_oe_in | {4{!rd_n_in}}) & pin_out | ~(dev_oe_in | {4{!rd_n_in}}) & last;
    if (!wr_n_in)
      mem <= pin_out;
  end
endmodule
